// File: rtl/frs_defines.svh
// Offsets, field positions, reset values and masks of the fault bookkeeping bank
// Notes on behaviour
// - A restore write copies the written 32-bit word into the fault status register.
// - During a restore write the stall flag position is ignored and the flag kept.
// - Only a resume register write clears the stall flag, never a restore write.
// - Restore register is 32-bit write-only; reads return zero.
// - Syndrome register is 32-bit read-write; software must not trust its reset value.
// - Nested translation: syndrome bits 23:16 capture the first-stage bank index.
// - Stage-2-only fault: first-stage bank index field holds an uninterpretable value.
// - Index field exists only in stage-2 format banks; otherwise reads unknown.
// - Index field valid only with nested support flag 1; else unknown, writes ignored.
// - Syndrome bit 11: 0 synchronous recording, 1 asynchronous recording.
// - Syndrome bit 10 is 1 for a table walk fault, else 0.
// - Syndrome bit 8 records security: 0 secure, 1 non-secure.
// - Secure bank: bit 8 after security override; non-secure bank: bit reserved.
// - Syndrome bit 6 is 0 for a data access.
// - Bit 6 is 1 for instruction access, after fetch type override.
// - Ordinary status writes clear bits written 1, except the stall flag; zeros leave bits unchanged.
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH

`define FRS_ADDR_W 5
`define FRS_OFF_STATUS 5'h00
`define FRS_OFF_RESTORE 5'h04
`define FRS_OFF_SYNDROME 5'h08
`define FRS_OFF_RESUME 5'h0C
`define FRS_OFF_CONFIG 5'h10
`define FRS_OFF_IRQ_STATUS 5'h14
`define FRS_OFF_IRQ_MASK 5'h18

`define FRS_STALL_BIT 30
`define FRS_STATUS_RST 32'h00000000

`define FRS_SYN_IDX_LSB 16
`define FRS_SYN_IDX_MSB 23
`define FRS_SYN_ASYNC_BIT 11
`define FRS_SYN_WALK_BIT 10
`define FRS_SYN_NS_BIT 8
`define FRS_SYN_FETCH_BIT 6
`define FRS_SYN_IDX_MASK 32'h00FF0000
`define FRS_SYN_NS_MASK 32'h00000100
`define FRS_SYN_RW_MASK 32'h00FF0D7F
`define FRS_SYN_RST 32'h00000000

`define FRS_CFG_NESTED_BIT 0
`define FRS_CFG_STAGE2_BIT 1
`define FRS_CFG_SECURE_BIT 2
`define FRS_CFG_MASK 32'h00000007
`define FRS_CFG_RST 32'h00000000

`define FRS_IRQ_FAULT_BIT 0
`define FRS_IRQ_STALL_BIT 1
`define FRS_IRQ_MASK_BITS 32'h00000003
`define FRS_IRQ_RST 32'h00000000

`endif

// File: rtl/frs_pkg.sv
// Types of the fault bookkeeping bank
package frs_pkg;

    // Override of a transaction attribute as configured per stream
    typedef enum logic [1:0] {
        FRS_OVR_NONE = 2'h0,
        FRS_OVR_RSVD = 2'h1,
        FRS_OVR_ZERO = 2'h2,
        FRS_OVR_ONE = 2'h3
    } frs_ovr_t;

    // One fault report from the translation engine, valid for one cycle
    typedef struct packed {
        logic valid;
        logic [31:0] status_set;
        logic stall;
        logic async_rec;
        logic walk_fault;
        logic nonsecure;
        logic fetch;
        logic stage2_only;
        logic [7:0] first_index;
        frs_ovr_t security_override_cfg;
        frs_ovr_t fetch_type_override;
    } frs_fault_t;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] syndrome;
        logic [31:0] config_w;
        logic [31:0] irq_status;
        logic [31:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
    } frs_state_t;

endpackage

// File: rtl/frs_bank.sv
// Fault status, restore and first syndrome registers behind a Wishbone slave
`timescale 1ns/1ps
`include "frs_defines.svh"

module frs_bank import frs_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`FRS_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire frs_fault_t fault_i,
    output logic stall_o,
    output logic irq_o
);

    frs_state_t st_r;
    frs_state_t st_nxt;

    // Applies a per-stream override to one attribute bit
    function automatic logic frs_apply(input frs_ovr_t ovr, input logic raw);
        logic res;
        res = raw;
        case (ovr)
            FRS_OVR_ZERO: res = 1'b0;
            FRS_OVR_ONE: res = 1'b1;
            default: res = raw;
        endcase
        return res;
    endfunction

    logic req;
    logic wr;
    logic [31:0] bmask;
    logic [31:0] wval;
    logic [31:0] syn_wmask;
    logic [31:0] fault_syn;
    logic nested_ok;
    logic secure_bank;
    logic [31:0] stall_m;
    logic [31:0] ev;

    assign stall_m = 32'h00000001 << `FRS_STALL_BIT;

    always_comb begin
        st_nxt = st_r;
        req = wb_cyc_i & wb_stb_i & ~st_r.ack;
        wr = req & wb_we_i;
        bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wval = wb_dat_i & bmask;
        nested_ok = st_r.config_w[`FRS_CFG_NESTED_BIT] & st_r.config_w[`FRS_CFG_STAGE2_BIT];
        secure_bank = st_r.config_w[`FRS_CFG_SECURE_BIT];
        // Index only writable where it exists; ns bit reserved in non-secure banks
        syn_wmask = `FRS_SYN_RW_MASK;
        if (!nested_ok) begin
            syn_wmask = syn_wmask & ~`FRS_SYN_IDX_MASK;
        end
        if (!secure_bank) begin
            syn_wmask = syn_wmask & ~`FRS_SYN_NS_MASK;
        end
        fault_syn = 32'h00000000;
        if (nested_ok && !fault_i.stage2_only) begin
            // Stage-2-only index means nothing, so zero is stored rather than a stray value
            fault_syn[`FRS_SYN_IDX_MSB:`FRS_SYN_IDX_LSB] = fault_i.first_index;
        end
        fault_syn[`FRS_SYN_ASYNC_BIT] = fault_i.async_rec;
        fault_syn[`FRS_SYN_WALK_BIT] = fault_i.walk_fault;
        fault_syn[`FRS_SYN_NS_BIT] = secure_bank &
            frs_apply(fault_i.security_override_cfg, fault_i.nonsecure);
        fault_syn[`FRS_SYN_FETCH_BIT] =
            frs_apply(fault_i.fetch_type_override, fault_i.fetch);
        ev = 32'h00000000;
        st_nxt.ack = req;
        st_nxt.rdata = 32'h00000000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `FRS_OFF_STATUS: st_nxt.rdata = st_r.status;
                `FRS_OFF_SYNDROME: st_nxt.rdata = st_r.syndrome & syn_wmask;
                `FRS_OFF_CONFIG: st_nxt.rdata = st_r.config_w;
                `FRS_OFF_IRQ_STATUS: st_nxt.rdata = st_r.irq_status;
                `FRS_OFF_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                `FRS_OFF_STATUS: begin
                    st_nxt.status = st_r.status & ~wval;
                    st_nxt.status[`FRS_STALL_BIT] = st_r.status[`FRS_STALL_BIT];
                end
                `FRS_OFF_RESTORE: begin
                    // Byte lanes not selected keep their old status bits
                    st_nxt.status = (st_r.status & ~bmask) | wval;
                    st_nxt.status = (st_nxt.status & ~stall_m) | (st_r.status & stall_m);
                end
                `FRS_OFF_SYNDROME: begin
                    st_nxt.syndrome = (st_r.syndrome & ~(bmask & syn_wmask)) |
                        (wval & syn_wmask);
                end
                `FRS_OFF_RESUME: begin
                    st_nxt.status[`FRS_STALL_BIT] = 1'b0;
                end
                `FRS_OFF_CONFIG: begin
                    st_nxt.config_w = ((st_r.config_w & ~bmask) | wval) & `FRS_CFG_MASK;
                end
                `FRS_OFF_IRQ_STATUS: begin
                    st_nxt.irq_status = st_r.irq_status & ~wval;
                end
                `FRS_OFF_IRQ_MASK: begin
                    st_nxt.irq_mask = ((st_r.irq_mask & ~bmask) | wval) & `FRS_IRQ_MASK_BITS;
                end
                default: begin
                end
            endcase
        end
        // A fault arriving with a clear or restore still lands: set wins
        if (fault_i.valid) begin
            st_nxt.status = st_nxt.status | fault_i.status_set;
            if (fault_i.stall) begin
                st_nxt.status[`FRS_STALL_BIT] = 1'b1;
                ev[`FRS_IRQ_STALL_BIT] = 1'b1;
            end
            st_nxt.syndrome = fault_syn;
            ev[`FRS_IRQ_FAULT_BIT] = 1'b1;
        end
        st_nxt.irq_status = st_nxt.irq_status | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.status <= `FRS_STATUS_RST;
            st_r.syndrome <= `FRS_SYN_RST;
            st_r.config_w <= `FRS_CFG_RST;
            st_r.irq_status <= `FRS_IRQ_RST;
            st_r.irq_mask <= `FRS_IRQ_RST;
            st_r.ack <= 1'b0;
            st_r.rdata <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;
    assign stall_o = st_r.status[`FRS_STALL_BIT];
    assign irq_o = |(st_r.irq_status & st_r.irq_mask);

endmodule // frs_bank

// File: testbench/frs_bank_properties.sv
// Bus and stall flag checks of the fault bookkeeping bank
`timescale 1ns/1ps
`include "frs_defines.svh"
module frs_bank_properties import frs_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`FRS_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire frs_fault_t fault_i,
    input wire logic stall_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic wr;
    // A fault in the same cycle may set the flag, so those cycles are left out
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && !fault_i.valid;
    AST_ACK: assert property (take |=> wb_ack_o) else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_RESTORE_KEEP: assert property (
        wr && wb_adr_i == `FRS_OFF_RESTORE |=> $stable(stall_o)) else $error("restore hit stall");
    AST_STATUS_KEEP: assert property (
        wr && wb_adr_i == `FRS_OFF_STATUS |=> $stable(stall_o)) else $error("status hit stall");
    AST_RESUME_CLR: assert property (
        wr && wb_adr_i == `FRS_OFF_RESUME |=> !stall_o) else $error("resume kept stall");
    AST_WO_READ: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == `FRS_OFF_RESTORE |-> wb_dat_o == 32'h0)
        else $error("restore read not zero");
    AST_SYN_RSVD: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == `FRS_OFF_SYNDROME
        |-> (wb_dat_o & ~`FRS_SYN_RW_MASK) == 32'h0) else $error("reserved bits set");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
endmodule // frs_bank_properties
bind frs_bank frs_bank_properties frs_bank_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fault_i(fault_i), .stall_o(stall_o), .irq_o(irq_o));

// File: testbench/frs_bank_tb.sv
// Register level tests of the fault bookkeeping bank
`timescale 1ns/1ps
`include "frs_defines.svh"
module frs_bank_tb import frs_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] q;
    frs_fault_t fault = '0;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, stall_o, irq_o;
    int miscompares = 0;
    int compares = 0;
    always #20 clk_i = ~clk_i;
    frs_bank frs_bank_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .fault_i(fault), .stall_o(stall_o), .irq_o(irq_o));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Values read right after an edge are the settled values of the cycle before it
    task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        req <= 1'b0;
        if (n >= 20) miscompares++;
    endtask
    // Flags: stall, async, walk, nonsecure, fetch, stage-2 only; then both overrides
    task flt(input logic [31:0] set, input logic [5:0] b, input logic [7:0] idx,
        input logic [3:0] ovr);
        @(posedge clk_i);
        fault <= {1'b1, set, b, idx, ovr};
        @(posedge clk_i);
        fault <= '0;
    endtask
    task tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_i);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b1, `FRS_OFF_RESTORE, 32'h400000A5);
        acc(1'b0, `FRS_OFF_STATUS, 32'h0);
        chk("status", q, 32'h000000A5);
        acc(1'b0, `FRS_OFF_RESTORE, 32'h0);
        chk("restore", q, 32'h0);
        acc(1'b0, 5'h1C, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test restore done");
        acc(1'b1, `FRS_OFF_IRQ_MASK, 32'h1);
        flt(32'h2, 6'h20, 8'h00, 4'h0);
        acc(1'b1, `FRS_OFF_RESTORE, 32'h11);
        acc(1'b0, `FRS_OFF_STATUS, 32'h0);
        chk("status", q, 32'h40000011);
        acc(1'b1, `FRS_OFF_STATUS, 32'hFFFFFFEF);
        acc(1'b0, `FRS_OFF_STATUS, 32'h0);
        chk("status", q, 32'h40000010);
        chk("stall", {31'h0, stall_o}, 32'h1);
        chk("irq", {31'h0, irq_o}, 32'h1);
        acc(1'b1, `FRS_OFF_IRQ_STATUS, 32'h3);
        acc(1'b0, `FRS_OFF_IRQ_STATUS, 32'h0);
        chk("irq status", q, 32'h0);
        chk("irq", {31'h0, irq_o}, 32'h0);
        acc(1'b1, `FRS_OFF_RESUME, 32'h0);
        acc(1'b0, `FRS_OFF_STATUS, 32'h0);
        chk("status", q, 32'h00000010);
        $display("test stall done");
        acc(1'b1, `FRS_OFF_CONFIG, 32'h7);
        flt(32'h0, 6'h1E, 8'h5A, 4'h0);
        acc(1'b0, `FRS_OFF_SYNDROME, 32'h0);
        chk("syndrome", q, 32'h005A0D40);
        flt(32'h0, 6'h04, 8'h01, 4'hB);
        acc(1'b0, `FRS_OFF_SYNDROME, 32'h0);
        chk("syndrome", q, 32'h00010040);
        flt(32'h0, 6'h01, 8'h77, 4'h0);
        acc(1'b0, `FRS_OFF_SYNDROME, 32'h0);
        chk("syndrome", q, 32'h0);
        acc(1'b1, `FRS_OFF_SYNDROME, 32'hFFFFFFFF);
        acc(1'b0, `FRS_OFF_SYNDROME, 32'h0);
        chk("syndrome", q, 32'h00FF0D7F);
        acc(1'b1, `FRS_OFF_CONFIG, 32'h0);
        flt(32'h0, 6'h04, 8'h33, 4'h0);
        acc(1'b0, `FRS_OFF_SYNDROME, 32'h0);
        chk("syndrome", q, 32'h0);
        chk("irq", {31'h0, irq_o}, 32'h1);
        acc(1'b1, `FRS_OFF_IRQ_MASK, 32'h0);
        acc(1'b0, `FRS_OFF_IRQ_STATUS, 32'h0);
        chk("irq status", q, 32'h1);
        chk("irq", {31'h0, irq_o}, 32'h0);
        $display("test syndrome done");
        tally_and_finish;
    end
endmodule // frs_bank_tb
